// ==== css_sequencer.sv ====
// charge state sequencer with Avalon-MM registers and one interrupt
// assumes comparator decisions arrive as asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module css_sequencer
	import css_pkg::*;
#(
	parameter int FILT_CYC = CSS_FILTER_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic uvlo_pin,
	input wire logic low_battery_sense_input,
	input wire logic vbat_above_95_pin,
	input wire logic vbat_below_90_pin,
	input wire logic taper_threshold_input,
	output logic state_code_bit0,
	output logic state_code_bit1,
	output logic float_indicator,
	output logic state_code_bit0_oe,
	output logic state_code_bit1_oe,
	output logic float_indicator_oe,
	output logic voltage_error_amp_en,
	output logic trickle_bias_current_en,
	output logic irq
);

	// pin levels driven in each state
	function automatic css_pins_type pins_of(input css_state_type s);
		css_pins_type p;
		p = '{bit1: 1'b0, bit0: 1'b0, float_ind: 1'b0};
		case (s)
			CSS_TRICKLE: p = '{bit1: 1'b0, bit0: 1'b0, float_ind: 1'b0};
			CSS_BULK: p = '{bit1: 1'b0, bit0: 1'b1, float_ind: 1'b0};
			CSS_OVER: p = '{bit1: 1'b1, bit0: 1'b0, float_ind: 1'b0};
			CSS_FLOAT: p = '{bit1: 1'b1, bit0: 1'b1, float_ind: 1'b1};
			default: p = '{bit1: 1'b0, bit0: 1'b0, float_ind: 1'b0};
		endcase
		return p;
	endfunction : pins_of

	// one-hot interrupt bit for entering a state
	function automatic logic [CSS_IRQ_W-1:0] entry_bit(
		input css_state_type s
	);
		logic [CSS_IRQ_W-1:0] b;
		b = '0;
		case (s)
			CSS_TRICKLE: b[CSS_IRQ_TRICKLE] = 1'b1;
			CSS_BULK: b[CSS_IRQ_BULK] = 1'b1;
			CSS_OVER: b[CSS_IRQ_OVER] = 1'b1;
			CSS_FLOAT: b[CSS_IRQ_FLOAT] = 1'b1;
			default: b = '0;
		endcase
		return b;
	endfunction : entry_bit

	// a register write lands only with its low byte enabled
	function automatic logic wr_hit(
		input logic [4:0] a,
		input logic [4:0] want,
		input logic be0
	);
		return (a == want) && be0;
	endfunction : wr_hit

	// comparator decisions, sequencer state and registered pin levels
	css_cmp_type cmp;
	css_state_type state_q;
	css_state_type state_d;
	css_pins_type pins_q;
	logic [CSS_DWELL_W-1:0] dwell_q;
	logic hold_trickle;

	// software registers and interrupt bookkeeping
	logic [1:0] ctrl_q;
	logic restart_q;
	logic [CSS_IRQ_W-1:0] irq_stat_q;
	logic [CSS_IRQ_W-1:0] irq_mask_q;
	logic [CSS_IRQ_W-1:0] events;
	logic [CSS_IRQ_W-1:0] rd_clear;
	logic uvlo_prev_q;

	// bus handshake terms
	logic ack_q;
	logic access;
	logic take;
	logic rd_take;
	logic wr_take;
	logic [31:0] rd_mux;

	// filtered comparator inputs; lockout starts asserted
	css_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_uvlo (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin(uvlo_pin),
		.level_q(cmp.uvlo)
	);
	css_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b0)) u_lowbat (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin(low_battery_sense_input),
		.level_q(cmp.lowbat_above)
	);
	css_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b0)) u_v95 (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin(vbat_above_95_pin),
		.level_q(cmp.vbat_above_95)
	);
	css_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b0)) u_v90 (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin(vbat_below_90_pin),
		.level_q(cmp.vbat_below_90)
	);
	css_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b0)) u_taper (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin(taper_threshold_input),
		.level_q(cmp.taper_below)
	);

	// bus handshake: every access waits exactly one cycle
	assign access = avs_read | avs_write;
	assign take = access & ~ack_q;
	assign avs_waitrequest = access & ~ack_q;

	// completing edge of a read or a write
	assign rd_take = avs_read & ack_q;
	assign wr_take = avs_write & ack_q;

	// acknowledge flag, cleared after the completing edge
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= take;
		end
	end

	// read multiplexer; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			CSS_OFS_CTRL: rd_mux[1:0] = ctrl_q;
			CSS_OFS_STATUS: begin
				rd_mux[CSS_ST_CODE_LSB +: 2] = {pins_q.bit1, pins_q.bit0};
				rd_mux[CSS_ST_FLOAT_BIT] = pins_q.float_ind;
				rd_mux[CSS_ST_CMP_LSB +: 5] = cmp;
			end
			CSS_OFS_IRQ_STAT: rd_mux[CSS_IRQ_W-1:0] = irq_stat_q;
			CSS_OFS_IRQ_MASK: rd_mux[CSS_IRQ_W-1:0] = irq_mask_q;
			CSS_OFS_DWELL: rd_mux = dwell_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured in the wait cycle, stands at the ack edge
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (take && avs_read) begin
			avs_readdata <= rd_mux;
		end
	end

	// control register: only the enable bit is stored
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= CSS_CTRL_RST;
		end else if (wr_take &&
			wr_hit(avs_address, CSS_OFS_CTRL, avs_byteenable[0])) begin
			ctrl_q[CSS_CTRL_EN_BIT] <= avs_writedata[CSS_CTRL_EN_BIT];
		end
	end

	// restart strobe: high for one cycle after a write of a one
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= wr_take &&
				wr_hit(avs_address, CSS_OFS_CTRL, avs_byteenable[0]) &&
				avs_writedata[CSS_CTRL_RESTART_BIT];
		end
	end

	// interrupt mask register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask_q <= CSS_IRQ_MASK_RST;
		end else if (wr_take &&
			wr_hit(avs_address, CSS_OFS_IRQ_MASK, avs_byteenable[0])) begin
			irq_mask_q <= avs_writedata[CSS_IRQ_W-1:0];
		end
	end

	// lockout, disable or a restart strobe pin the sequencer to trickle
	assign hold_trickle = cmp.uvlo | ~ctrl_q[CSS_CTRL_EN_BIT] | restart_q;

	// next state from the filtered comparator decisions
	always_comb begin
		state_d = state_q;
		if (hold_trickle) begin
			state_d = CSS_TRICKLE;
		end else begin
			case (state_q)
				CSS_TRICKLE: begin
					if (cmp.lowbat_above) begin
						state_d = CSS_BULK;
					end
				end
				CSS_BULK: begin
					if (!cmp.lowbat_above) begin
						state_d = CSS_TRICKLE;
					end else if (cmp.vbat_above_95) begin
						state_d = CSS_OVER;
					end
				end
				CSS_OVER: begin
					if (!cmp.lowbat_above) begin
						state_d = CSS_TRICKLE;
					end else if (cmp.taper_below) begin
						state_d = CSS_FLOAT;
					end
				end
				CSS_FLOAT: begin
					if (!cmp.lowbat_above) begin
						state_d = CSS_TRICKLE;
					end else if (cmp.vbat_below_90) begin
						state_d = CSS_BULK;
					end
				end
				default: state_d = CSS_TRICKLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= CSS_TRICKLE;
		end else begin
			state_q <= state_d;
		end
	end

	// pin levels registered from the next state, so they track state_q
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pins_q <= pins_of(CSS_TRICKLE);
		end else begin
			pins_q <= pins_of(state_d);
		end
	end

	// analog gating: amp off and bias on only in trickle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			voltage_error_amp_en <= 1'b0;
			trickle_bias_current_en <= 1'b1;
		end else begin
			voltage_error_amp_en <= (state_d != CSS_TRICKLE);
			trickle_bias_current_en <= (state_d == CSS_TRICKLE);
		end
	end

	// pin levels straight from their flops
	assign state_code_bit0 = pins_q.bit0;
	assign state_code_bit1 = pins_q.bit1;
	assign float_indicator = pins_q.float_ind;

	// open-collector enables: the pin is pulled low for a zero
	assign state_code_bit0_oe = ~pins_q.bit0;
	assign state_code_bit1_oe = ~pins_q.bit1;
	assign float_indicator_oe = ~pins_q.float_ind;

	// cycles spent in the present state, saturating
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dwell_q <= '0;
		end else if (state_d != state_q) begin
			dwell_q <= '0;
		end else if (dwell_q != '1) begin
			dwell_q <= dwell_q + 1'b1;
		end
	end

	// lockout edge memory for its interrupt event
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			uvlo_prev_q <= 1'b1;
		end else begin
			uvlo_prev_q <= cmp.uvlo;
		end
	end

	// events: state entries and a fresh lockout assertion
	always_comb begin
		events = '0;
		if (state_d != state_q) begin
			events = entry_bit(state_d);
		end
		events[CSS_IRQ_UVLO] = cmp.uvlo & ~uvlo_prev_q;
	end

	// a read clears only the bits it returned; later events survive
	assign rd_clear = (rd_take && avs_address == CSS_OFS_IRQ_STAT) ?
		avs_readdata[CSS_IRQ_W-1:0] : '0;

	// sticky status, cleared by reading it; a new event wins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~rd_clear) | events;
		end
	end

	// level interrupt while any unmasked status bit is set
	assign irq = |(irq_stat_q & irq_mask_q);

endmodule : css_sequencer
`default_nettype wire

// ==== css_pkg.sv ====
// constants and types shared by the charge state sequencer files
// assumes a single 100 MHz core clock and an Avalon-MM register bus
package css_pkg;

	// clock and input filter timing
	localparam int CSS_CLK_NS = 10;
	localparam int CSS_FILTER_NS = 1000;
	localparam int CSS_FILTER_CYC =
		(CSS_FILTER_NS + CSS_CLK_NS - 1) / CSS_CLK_NS;

	// register byte offsets
	localparam logic [4:0] CSS_OFS_CTRL = 5'h00;
	localparam logic [4:0] CSS_OFS_STATUS = 5'h04;
	localparam logic [4:0] CSS_OFS_IRQ_STAT = 5'h08;
	localparam logic [4:0] CSS_OFS_IRQ_MASK = 5'h0C;
	localparam logic [4:0] CSS_OFS_DWELL = 5'h10;

	// control register fields and reset value
	localparam int CSS_CTRL_EN_BIT = 0;
	localparam int CSS_CTRL_RESTART_BIT = 1;
	localparam logic [1:0] CSS_CTRL_RST = 2'h1;

	// status register field positions
	localparam int CSS_ST_CODE_LSB = 0;
	localparam int CSS_ST_FLOAT_BIT = 2;
	localparam int CSS_ST_CMP_LSB = 4;

	// interrupt bit positions (status and mask share them)
	localparam int CSS_IRQ_TRICKLE = 0;
	localparam int CSS_IRQ_BULK = 1;
	localparam int CSS_IRQ_OVER = 2;
	localparam int CSS_IRQ_FLOAT = 3;
	localparam int CSS_IRQ_UVLO = 4;
	localparam int CSS_IRQ_W = 5;
	localparam logic [CSS_IRQ_W-1:0] CSS_IRQ_MASK_RST = 5'h00;

	// dwell counter width
	localparam int CSS_DWELL_W = 32;

	// charge states, gray coded along trickle-bulk-over-float
	typedef enum logic [1:0] {
		CSS_TRICKLE = 2'h0,
		CSS_BULK = 2'h1,
		CSS_OVER = 2'h3,
		CSS_FLOAT = 2'h2
	} css_state_type;

	// filtered comparator decisions
	typedef struct packed {
		logic uvlo;
		logic lowbat_above;
		logic vbat_above_95;
		logic vbat_below_90;
		logic taper_below;
	} css_cmp_type;

	// pin level outputs of one state
	typedef struct packed {
		logic bit1;
		logic bit0;
		logic float_ind;
	} css_pins_type;

endpackage : css_pkg

// ==== css_filt.sv ====
// two-flop synchroniser followed by a stability filter for one pin
// assumes the pin is asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module css_filt
	import css_pkg::*;
#(
	parameter int FILT_CYC = CSS_FILTER_CYC,
	parameter logic RST_VAL = 1'b0
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic pin,
	output logic level_q
);
	localparam int CW = $clog2(FILT_CYC + 1);
	logic meta_q;
	logic sync_q;
	logic [CW-1:0] cnt_q;

	// first flop feeds only the second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end

	// level follows only after FILT_CYC stable samples
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			level_q <= RST_VAL;
		end else if (sync_q == level_q) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(FILT_CYC - 1)) begin
			cnt_q <= '0;
			level_q <= sync_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : css_filt
`default_nettype wire

// ==== css_sequencer_checker.sv ====
// port assertions for the charge state sequencer
// assumes one core clock and the bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module css_sequencer_checker
	import css_pkg::*;
#(
	parameter int FILT_CYC = 3
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic uvlo_pin,
	input wire logic taper_threshold_input,
	input wire logic state_code_bit0,
	input wire logic state_code_bit1,
	input wire logic float_indicator,
	input wire logic state_code_bit0_oe,
	input wire logic state_code_bit1_oe,
	input wire logic float_indicator_oe,
	input wire logic voltage_error_amp_en,
	input wire logic trickle_bias_current_en,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	localparam int TAPER_MAX = FILT_CYC + 6;
	localparam int UVLO_MAX = FILT_CYC + 4;
	logic [1:0] code;
	int taper_age_q;
	int uvlo_run_q;
	assign code = {state_code_bit1, state_code_bit0};
	// age of the last taper sighting, length of the lockout run
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			taper_age_q <= 1000;
			uvlo_run_q <= 0;
		end else begin
			taper_age_q <= taper_threshold_input ? 0 : taper_age_q + 1;
			uvlo_run_q <= uvlo_pin ? uvlo_run_q + 1 : 0;
		end
	end
	sequence s_in_over;
		code == 2'h2;
	endsequence
	sequence s_to_float;
		code == 2'h3;
	endsequence
	a_taper_cause: assert property (
		s_in_over ##1 s_to_float |-> taper_age_q <= TAPER_MAX)
		else $error("float entered without taper");
	a_legal_moves: assert property (
		code != $past(code) |-> code == 2'h0 ||
		code == ($past(code) == 2'h3 ? 2'h1 : $past(code) + 2'h1))
		else $error("illegal state move");
	a_float_code: assert property (
		float_indicator == (state_code_bit1 & state_code_bit0))
		else $error("float level disagrees with code");
	a_oe_inverse: assert property (
		state_code_bit0_oe != state_code_bit0 &&
		state_code_bit1_oe != state_code_bit1 &&
		float_indicator_oe != float_indicator)
		else $error("open collector enable wrong");
	a_trickle_amp: assert property (
		code == 2'h0 |-> !voltage_error_amp_en && trickle_bias_current_en)
		else $error("trickle amp or bias wrong");
	a_bulk_amp: assert property (
		code != 2'h0 |-> voltage_error_amp_en && !trickle_bias_current_en)
		else $error("charging amp or bias wrong");
	a_uvlo_hold: assert property (
		uvlo_run_q > UVLO_MAX |-> code == 2'h0 && !float_indicator)
		else $error("lockout did not hold trickle");
	a_bus_wait: assert property (
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus wait cycle wrong");
	a_reset_vals: assert property (
		$rose(resetn) |-> code == 2'h0 && !float_indicator && !irq &&
		!voltage_error_amp_en && trickle_bias_current_en)
		else $error("reset values wrong");
endmodule : css_sequencer_checker
bind css_sequencer css_sequencer_checker #(.FILT_CYC(FILT_CYC)) chk_inst (
	.core_clk, .resetn, .avs_read, .avs_write, .avs_waitrequest, .uvlo_pin,
	.taper_threshold_input, .state_code_bit0, .state_code_bit1,
	.float_indicator, .state_code_bit0_oe, .state_code_bit1_oe,
	.float_indicator_oe, .voltage_error_amp_en, .trickle_bias_current_en,
	.irq
);
`default_nettype wire

// ==== css_batt_model.sv ====
// battery, sense divider and comparators beside the sequencer
// assumes the bench moves battery level and current in percent
`timescale 1ns/100ps
`default_nettype none
module css_batt_model #(
	parameter logic [7:0] LOWBAT_PCT = 8'h46
) (
	input wire logic [7:0] vbat_pct,
	input wire logic [7:0] ichg_pct,
	output logic low_battery_sense_input,
	output logic vbat_above_95_pin,
	output logic vbat_below_90_pin,
	output logic taper_threshold_input
);
	// comparator decisions follow the battery at once
	assign low_battery_sense_input = vbat_pct > LOWBAT_PCT;
	assign vbat_above_95_pin = vbat_pct > 8'h5F;
	assign vbat_below_90_pin = vbat_pct < 8'h5A;
	assign taper_threshold_input = ichg_pct < 8'h0A;
endmodule : css_batt_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the charge state sequencer
// assumes css_batt_model drives the comparator pins except the lockout pin
`timescale 1ns/100ps
`default_nettype none
module tb
	import css_pkg::*;
;
	localparam int FILT = 3;
	logic clk, resetn, rd, wr, uvlo, irq, wait_r, lowbat, v95, v90, taper;
	logic bit0, bit1, flt, oe0, oe1, oef, amp_en, bias_en;
	logic [4:0] addr;
	logic [3:0] be;
	logic [31:0] wdata, rdata, r;
	logic [7:0] vbat, ichg;
	logic [31:0] rd_q[$];
	logic [2:0] st_q[$];
	logic [2:0] seen;
	integer seed;
	int errors, checks_done;
	css_sequencer #(.FILT_CYC(FILT)) css_sequencer_inst (
		.core_clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wait_r), .uvlo_pin(uvlo),
		.low_battery_sense_input(lowbat), .vbat_above_95_pin(v95),
		.vbat_below_90_pin(v90), .taper_threshold_input(taper),
		.state_code_bit0(bit0), .state_code_bit1(bit1), .float_indicator(flt),
		.state_code_bit0_oe(oe0), .state_code_bit1_oe(oe1),
		.float_indicator_oe(oef), .voltage_error_amp_en(amp_en),
		.trickle_bias_current_en(bias_en), .irq(irq)
	);
	css_batt_model css_batt_model_inst (
		.vbat_pct(vbat), .ichg_pct(ichg), .low_battery_sense_input(lowbat),
		.vbat_above_95_pin(v95), .vbat_below_90_pin(v90),
		.taper_threshold_input(taper)
	);
	// free running core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, e, s);
		end
	endtask : check
	task automatic close_out;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	// one bus access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		if (!w) rd_q.push_back(d);
		do @(posedge clk); while (wait_r !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic settle;
		while (st_q.size() != 0) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask : settle
	// results are matched against the oldest note as they appear
	always @(posedge clk) begin
		if (rd && wait_r === 1'b0) begin
			if (rd_q.size() == 0) check("extra read", 32'h1, 32'h0);
			else check("readdata", rdata, rd_q.pop_front());
		end
		if (resetn && {bit1, bit0, flt} !== seen) begin
			if (st_q.size() == 0) check("extra state", 32'h1, 32'h0);
			else check("state", 32'({bit1, bit0, flt}), 32'(st_q.pop_front()));
		end
		seen = {bit1, bit0, flt};
	end
	// cut a hang short
	initial begin
		#200000;
		errors++;
		close_out;
	end
	initial begin
		seed = 32'hDDA5;
		errors = 0;
		checks_done = 0;
		{resetn, rd, wr, addr, wdata} = '0;
		be = 4'hF;
		uvlo = 1'b1;
		vbat = 8'h00;
		ichg = 8'h32;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		bus(1'b0, CSS_OFS_CTRL, {30'h0, CSS_CTRL_RST});
		bus(1'b0, CSS_OFS_IRQ_MASK, 32'h0);
		bus(1'b0, 5'h14, 32'h0);
		bus(1'b0, CSS_OFS_IRQ_STAT, 32'h0);
		bus(1'b1, CSS_OFS_IRQ_MASK, 32'h1F);
		uvlo <= 1'b0;
		repeat (FILT + 8) @(posedge clk);
		r = $random(seed);
		st_q.push_back(3'b010);
		vbat <= 8'h47 + {4'h0, r[3:0]};
		settle;
		bus(1'b0, CSS_OFS_STATUS, 32'h0000_00A1);
		be <= 4'hE;
		bus(1'b1, CSS_OFS_CTRL, 32'h0);
		be <= 4'hF;
		bus(1'b0, CSS_OFS_CTRL, 32'h1);
		st_q.push_back(3'b000);
		bus(1'b1, CSS_OFS_CTRL, 32'h0);
		settle;
		bus(1'b0, CSS_OFS_CTRL, 32'h0);
		st_q.push_back(3'b010);
		bus(1'b1, CSS_OFS_CTRL, 32'h1);
		settle;
		st_q.push_back(3'b000);
		st_q.push_back(3'b010);
		bus(1'b1, CSS_OFS_CTRL, 32'h3);
		settle;
		bus(1'b0, CSS_OFS_CTRL, 32'h1);
		bus(1'b0, CSS_OFS_IRQ_STAT, 32'h03);
		ichg <= 8'h05;
		repeat (4 * FILT) @(posedge clk);
		check("taper in bulk", 32'({bit1, bit0, flt}), 32'h2);
		st_q.push_back(3'b100);
		st_q.push_back(3'b111);
		vbat <= 8'h60;
		settle;
		st_q.push_back(3'b010);
		vbat <= 8'h55;
		settle;
		check("irq", 32'(irq), 32'h1);
		bus(1'b0, CSS_OFS_IRQ_STAT, 32'h0E);
		@(posedge clk);
		check("irq cleared", 32'(irq), 32'h0);
		bus(1'b1, CSS_OFS_IRQ_MASK, 32'h0);
		st_q.push_back(3'b000);
		vbat <= 8'h20;
		settle;
		check("irq masked", 32'(irq), 32'h0);
		bus(1'b0, CSS_OFS_IRQ_STAT, 32'h01);
		bus(1'b1, CSS_OFS_IRQ_MASK, 32'h1F);
		st_q.push_back(3'b010);
		vbat <= 8'h50;
		settle;
		st_q.push_back(3'b000);
		uvlo <= 1'b1;
		settle;
		check("irq lockout", 32'(irq), 32'h1);
		bus(1'b0, CSS_OFS_IRQ_STAT, 32'h13);
		close_out;
	end
endmodule : tb
`default_nettype wire
